//--- inc/fosr_pkg.sv
// constants and types shared by the flash status polling controller
`default_nettype none
package fosr_pkg;
    // ------------------------------------------------------------------
    // clock and flash bus timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_ACC_NS      = 90;
    localparam int T_WP_NS       = 35;
    // least times round up to whole cycles
    localparam int RD_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W  = 3;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int FA_W = 22;
    localparam int FD_W = 8;
    localparam int SA_W = 8;
    localparam int SD_W = 32;

    // ------------------------------------------------------------------
    // software register map
    // ------------------------------------------------------------------
    localparam logic [SA_W-1:0] REG_CTRL = 8'h00;
    localparam logic [SA_W-1:0] REG_ADDR = 8'h04;
    localparam logic [SA_W-1:0] REG_DATA = 8'h08;
    localparam logic [SA_W-1:0] REG_STAT = 8'h0C;
    localparam logic [SA_W-1:0] REG_LAST = 8'h10;

    // control register: command field and abort bit
    localparam int CTRL_CMD_LO = 0;
    localparam int CTRL_ABORT  = 2;
    localparam logic [1:0] CMD_NONE      = 2'h0;
    localparam logic [1:0] CMD_POLL      = 2'h1;
    localparam logic [1:0] CMD_WRITE     = 2'h2;
    localparam logic [1:0] CMD_ERASE_ADD = 2'h3;

    // status register bits
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_REJECT  = 4;
    localparam int ST_UNSURE  = 5;
    localparam int ST_READY   = 6;
    localparam int ST_ABORTED = 7;

    // flash status byte layout
    localparam int BIT_POLLING = 7;
    localparam int BIT_TOGGLE  = 6;
    localparam int BIT_TIMEOUT = 5;
    localparam int BIT_WINDOW  = 3;
    localparam int BIT_SECTOR  = 2;

    // reset command word, accepted at any address
    localparam logic [FD_W-1:0] FL_RESET_CMD  = 8'hF0;
    localparam logic [FA_W-1:0] FL_RESET_ADDR = 22'h000000;

    // reset values
    localparam logic [FA_W-1:0] ADDR_RST = 22'h000000;
    localparam logic [FD_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_R1   = 4'h1,
        S_R2   = 4'h2,
        S_R3   = 4'h3,
        S_R4   = 4'h4,
        S_RST  = 4'h5,
        S_WR   = 4'h6,
        S_RA   = 4'h7,
        S_RB   = 4'h8
    } fosr_state_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'h0,
        C_ACT  = 2'h1,
        C_REC  = 2'h2
    } fosr_cyc_t;
endpackage
`default_nettype wire

//--- logic/fosr_cycle.sv
// one asynchronous flash bus cycle, read or write
`default_nettype none
module fosr_cycle
    import fosr_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rstn,
    input  wire logic                     start,
    input  wire logic                     is_write,
    input  wire logic [fosr_pkg::FA_W-1:0] addr,
    input  wire logic [fosr_pkg::FD_W-1:0] wdata,
    output logic                          done,
    output logic [fosr_pkg::FD_W-1:0]      rdata,
    output logic [fosr_pkg::FA_W-1:0]      fl_a,
    input  wire logic [fosr_pkg::FD_W-1:0] fl_dq_i,
    output logic [fosr_pkg::FD_W-1:0]      fl_dq_o,
    output logic                          fl_dq_oe,
    output logic                          fl_ce_n,
    output logic                          fl_oe_n,
    output logic                          fl_we_n
);
    import fosr_pkg::*;

    fosr_cyc_t              st_q,  st_d;
    logic [CNT_W-1:0]       cnt_q, cnt_d;
    logic                   wr_q,  wr_d;
    logic [FA_W-1:0]        a_q,   a_d;
    logic [FD_W-1:0]        wd_q,  wd_d;
    logic [FD_W-1:0]        rd_q,  rd_d;
    logic [CNT_W-1:0]       lim;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        wr_d  = wr_q;
        a_d   = a_q;
        wd_d  = wd_q;
        rd_d  = rd_q;
        done  = 1'b0;
        lim   = wr_q ? CNT_W'(WP_CYC - 1) : CNT_W'(RD_CYC - 1);
        unique case (st_q)
            C_IDLE: begin
                if (start) begin
                    st_d  = C_ACT;
                    cnt_d = '0;
                    wr_d  = is_write;
                    a_d   = addr;
                    wd_d  = wdata;
                end
            end
            C_ACT: begin
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q == lim) begin
                    st_d = C_REC;
                    if (!wr_q) begin
                        rd_d = fl_dq_i;
                    end
                end
            end
            C_REC: begin
                // strobes are high here, so every read ends with an edge
                done = 1'b1;
                st_d = C_IDLE;
            end
            default: st_d = C_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_q  <= C_IDLE;
            cnt_q <= '0;
            wr_q  <= 1'b0;
            a_q   <= ADDR_RST;
            wd_q  <= DATA_RST;
            rd_q  <= DATA_RST;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            wr_q  <= wr_d;
            a_q   <= a_d;
            wd_q  <= wd_d;
            rd_q  <= rd_d;
        end
    end

    // a read is ended by both chip select and output strobe rising
    assign fl_ce_n  = (st_q != C_ACT);
    assign fl_oe_n  = !(st_q == C_ACT && !wr_q);
    assign fl_we_n  = !(st_q == C_ACT && wr_q);
    // data held through recovery so it meets hold after the write edge
    assign fl_dq_oe = wr_q && (st_q != C_IDLE);
    assign fl_dq_o  = wd_q;
    assign fl_a     = a_q;
    assign rdata    = rd_q;
endmodule
`default_nettype wire

//--- logic/fosr_host.sv
// host controller that polls flash program and erase status
`default_nettype none
// Behaviour
// - host ends reads with output strobe and select rising together
// - host reads twice, compares toggle bit values
// - toggling with timeout set: recheck, then reset if still toggling
// - resumed polling restarts from its first step
// - host issues reset command after timeout failure
// - host checks window flag around added erases
module fosr_host
    import fosr_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rstn,
    input  wire logic [fosr_pkg::SA_W-1:0] sw_addr,
    input  wire logic [fosr_pkg::SD_W-1:0] sw_wdata,
    input  wire logic                     sw_wr,
    input  wire logic                     sw_rd,
    output logic [fosr_pkg::SD_W-1:0]      sw_rdata,
    output logic [fosr_pkg::FA_W-1:0]      fl_a,
    input  wire logic [fosr_pkg::FD_W-1:0] fl_dq_i,
    output logic [fosr_pkg::FD_W-1:0]      fl_dq_o,
    output logic                          fl_dq_oe,
    output logic                          fl_ce_n,
    output logic                          fl_oe_n,
    output logic                          fl_we_n,
    input  wire logic                     ready_busy_n_pin
);
    import fosr_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fosr_state_t        st_q,   st_d;
    logic [1:0]         mode_q, mode_d;
    logic               pend_q, pend_d;
    logic               t1_q,   t1_d;
    logic [FD_W-1:0]    last_q, last_d;
    logic [FA_W-1:0]    addr_q, addr_d;
    logic [FD_W-1:0]    data_q, data_d;
    logic               done_q, done_d;
    logic               fail_q, fail_d;
    logic               to_q,   to_d;
    logic               rej_q,  rej_d;
    logic               uns_q,  uns_d;
    logic               abt_q,  abt_d;
    logic [SD_W-1:0]    rdat_q, rdat_d;

    logic               cyc_start;
    logic               cyc_wr;
    logic               cyc_done;
    logic [FA_W-1:0]    cyc_addr;
    logic [FD_W-1:0]    cyc_wdata;
    logic [FD_W-1:0]    rd;
    logic               ctrl_wr;
    logic [1:0]         cmd;
    logic [SD_W-1:0]    stat_word;

    // ------------------------------------------------------------------
    // flash bus cycle engine
    // ------------------------------------------------------------------
    assign cyc_start = (st_q != S_IDLE) && !pend_q;
    assign cyc_wr    = (st_q == S_WR) || (st_q == S_RST);
    assign cyc_addr  = (st_q == S_RST) ? FL_RESET_ADDR : addr_q;
    assign cyc_wdata = (st_q == S_RST) ? FL_RESET_CMD : data_q;

    fosr_cycle u_cycle (
        .clock    (clock),
        .rstn     (rstn),
        .start    (cyc_start),
        .is_write (cyc_wr),
        .addr     (cyc_addr),
        .wdata    (cyc_wdata),
        .done     (cyc_done),
        .rdata    (rd),
        .fl_a     (fl_a),
        .fl_dq_i  (fl_dq_i),
        .fl_dq_o  (fl_dq_o),
        .fl_dq_oe (fl_dq_oe),
        .fl_ce_n  (fl_ce_n),
        .fl_oe_n  (fl_oe_n),
        .fl_we_n  (fl_we_n)
    );

    assign ctrl_wr = sw_wr && (sw_addr == REG_CTRL);
    assign cmd     = sw_wdata[CTRL_CMD_LO +: 2];

    always_comb begin
        stat_word              = '0;
        stat_word[ST_BUSY]     = (st_q != S_IDLE);
        stat_word[ST_DONE]     = done_q;
        stat_word[ST_FAIL]     = fail_q;
        stat_word[ST_TIMEOUT]  = to_q;
        stat_word[ST_REJECT]   = rej_q;
        stat_word[ST_UNSURE]   = uns_q;
        // pulled-up shared line: low means some device is busy
        stat_word[ST_READY]    = ready_busy_n_pin;
        stat_word[ST_ABORTED]  = abt_q;
    end

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        mode_d = mode_q;
        pend_d = pend_q;
        t1_d   = t1_q;
        last_d = last_q;
        addr_d = addr_q;
        data_d = data_q;
        done_d = done_q;
        fail_d = fail_q;
        to_d   = to_q;
        rej_d  = rej_q;
        uns_d  = uns_q;
        abt_d  = abt_q;

        if (cyc_start) begin
            pend_d = 1'b1;
        end else if (cyc_done) begin
            pend_d = 1'b0;
        end
        if (cyc_done && !cyc_wr) begin
            last_d = rd;
        end

        // address and data only change while idle
        if (sw_wr && st_q == S_IDLE && sw_addr == REG_ADDR) begin
            addr_d = sw_wdata[FA_W-1:0];
        end
        if (sw_wr && st_q == S_IDLE && sw_addr == REG_DATA) begin
            data_d = sw_wdata[FD_W-1:0];
        end
        if (ctrl_wr && sw_wdata[CTRL_ABORT] && st_q != S_IDLE) begin
            abt_d = 1'b1;
        end

        unique case (st_q)
            S_IDLE: begin
                if (ctrl_wr && cmd != CMD_NONE) begin
                    mode_d = cmd;
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    to_d   = 1'b0;
                    rej_d  = 1'b0;
                    uns_d  = 1'b0;
                    abt_d  = 1'b0;
                    unique case (cmd)
                        CMD_POLL:  st_d = S_R1;
                        CMD_WRITE: st_d = S_WR;
                        default:   st_d = S_RA;
                    endcase
                end
            end
            S_R1: begin
                if (cyc_done) begin
                    t1_d = rd[BIT_TOGGLE];
                    st_d = S_R2;
                end
            end
            S_R2: begin
                if (cyc_done) begin
                    if (rd[BIT_TOGGLE] == t1_q) begin
                        // toggle stopped: operation is over
                        st_d   = S_IDLE;
                        done_d = 1'b1;
                    end else if (rd[BIT_TIMEOUT]) begin
                        to_d = 1'b1;
                        st_d = S_R3;
                    end else if (abt_q || abt_d) begin
                        // a later poll starts again from the first read
                        st_d = S_IDLE;
                    end else begin
                        st_d = S_R1;
                    end
                end
            end
            S_R3: begin
                if (cyc_done) begin
                    t1_d = rd[BIT_TOGGLE];
                    st_d = S_R4;
                end
            end
            S_R4: begin
                if (cyc_done) begin
                    if (rd[BIT_TOGGLE] == t1_q) begin
                        // stopped just as the timeout rose: success
                        st_d   = S_IDLE;
                        done_d = 1'b1;
                    end else begin
                        fail_d = 1'b1;
                        st_d   = S_RST;
                    end
                end
            end
            S_RST: begin
                if (cyc_done) begin
                    st_d   = S_IDLE;
                    done_d = 1'b1;
                end
            end
            S_WR: begin
                if (cyc_done) begin
                    if (mode_q == CMD_ERASE_ADD) begin
                        st_d = S_RB;
                    end else begin
                        st_d   = S_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            S_RA: begin
                if (cyc_done) begin
                    if (rd[BIT_WINDOW]) begin
                        // erase already running: extra sector is refused
                        rej_d  = 1'b1;
                        st_d   = S_IDLE;
                        done_d = 1'b1;
                    end else begin
                        st_d = S_WR;
                    end
                end
            end
            S_RB: begin
                if (cyc_done) begin
                    // window closed right after: command may be lost
                    uns_d  = rd[BIT_WINDOW];
                    st_d   = S_IDLE;
                    done_d = 1'b1;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // software read port, data one cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rdat_d = '0;
        if (sw_rd) begin
            unique case (sw_addr)
                REG_CTRL: rdat_d = SD_W'(mode_q);
                REG_ADDR: rdat_d = SD_W'(addr_q);
                REG_DATA: rdat_d = SD_W'(data_q);
                REG_STAT: rdat_d = stat_word;
                REG_LAST: rdat_d = SD_W'(last_q);
                default:  rdat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_q   <= S_IDLE;
            mode_q <= CMD_NONE;
            pend_q <= 1'b0;
            t1_q   <= 1'b0;
            last_q <= DATA_RST;
            addr_q <= ADDR_RST;
            data_q <= DATA_RST;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            to_q   <= 1'b0;
            rej_q  <= 1'b0;
            uns_q  <= 1'b0;
            abt_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            st_q   <= st_d;
            mode_q <= mode_d;
            pend_q <= pend_d;
            t1_q   <= t1_d;
            last_q <= last_d;
            addr_q <= addr_d;
            data_q <= data_d;
            done_q <= done_d;
            fail_q <= fail_d;
            to_q   <= to_d;
            rej_q  <= rej_d;
            uns_q  <= uns_d;
            abt_q  <= abt_d;
            rdat_q <= rdat_d;
        end
    end

    assign sw_rdata = rdat_q;
endmodule
`default_nettype wire

//--- test/fosr_flash_model.sv
// behavioural flash device answering status polls
`default_nettype none
module fosr_flash_model
    import fosr_pkg::*;
(
    input  wire logic [fosr_pkg::FA_W-1:0] fl_a,
    input  wire logic [fosr_pkg::FD_W-1:0] fl_dq_o,
    input  wire logic                      fl_ce_n,
    input  wire logic                      fl_oe_n,
    input  wire logic                      fl_we_n,
    output logic      [fosr_pkg::FD_W-1:0] dq,
    output logic                           rb_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // status reads still to answer; -1 keeps the device busy for good
    int              busy_left = 0;
    int              n_rd = 0;
    int              n_wr = 0;
    logic            tmo = 1'b0;
    // erase suspended: toggle frozen and ready line released
    logic            susp = 1'b0;
    logic            win = 1'b0;
    logic            win_after = 1'b0;
    logic            tgl = 1'b0;
    logic            sec = 1'b0;
    logic [FD_W-1:0] arr = 8'hA5;
    logic [FD_W-1:0] last = 8'h00;
    logic [FD_W-1:0] wd = 8'h00;
    logic [FA_W-1:0] wa = 22'h000000;
    logic [FD_W-1:0] rv;
    wire             rd_on = !fl_ce_n && !fl_oe_n;

    assign rb_low = busy_left != 0 && !susp;
    assign rv = (busy_left != 0) ?
        {~arr[7], tgl, tmo, 1'b0, win, sec, 2'b00} : arr;
    // a released bus shows the inverse of the last byte, not a stale copy
    assign dq = rd_on ? rv : ~last;

    // either strobe rising ends the read
    always @(negedge rd_on) begin
        last = rv;
        n_rd++;
        if (busy_left != 0 && !susp) begin
            tgl = ~tgl;
        end
        if (busy_left != 0) begin
            sec = ~sec;
        end
        // a finite count stands for a short toggle, then array read
        if (busy_left > 0) busy_left--;
    end

    always @(posedge fl_we_n) begin
        n_wr++;
        wa = fl_a;
        wd = fl_dq_o;
        if (fl_dq_o == FL_RESET_CMD) begin
            busy_left = 0;
            tmo = 1'b0;
        end else begin
            win = win_after;
        end
    end
endmodule
`default_nettype wire

//--- test/fosr_host_props.sv
// bus-shape checker for the flash status polling controller
`default_nettype none
module fosr_host_props
    import fosr_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      rstn,
    input wire logic [fosr_pkg::FA_W-1:0] fl_a,
    input wire logic [fosr_pkg::FD_W-1:0] fl_dq_o,
    input wire logic                      fl_dq_oe,
    input wire logic                      fl_ce_n,
    input wire logic                      fl_oe_n,
    input wire logic                      fl_we_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------------
    // cycle shapes
    // ------------------------------------------------------------------
    // both strobes rise together so the device counts exactly one read
    sequence s_read;
        !fl_oe_n [*4] ##1 (fl_oe_n && fl_ce_n);
    endsequence
    sequence s_write;
        (!fl_we_n && fl_dq_oe) [*2] ##1 (fl_we_n && fl_dq_oe);
    endsequence

    AST_READ_SHAPE: assert property ($fell(fl_oe_n) |-> s_read)
        else $error("read strobe shape wrong");
    AST_WRITE_SHAPE: assert property ($fell(fl_we_n) |-> s_write)
        else $error("write strobe shape wrong");
    AST_CE_WITH_STROBE: assert property (
        (!fl_oe_n || !fl_we_n) |-> !fl_ce_n)
        else $error("strobe without chip select");
    AST_NO_CLASH: assert property (!fl_oe_n |-> fl_we_n && !fl_dq_oe)
        else $error("bus driven during read");
    AST_GAP: assert property ($rose(fl_ce_n) |-> fl_ce_n [*2])
        else $error("cycles too close");
    AST_WDATA_HOLD: assert property (
        !fl_we_n && !$past(fl_we_n) |-> $stable(fl_dq_o) && $stable(fl_a))
        else $error("write data moved");
    AST_ADDR_HOLD: assert property (
        !fl_oe_n && !$past(fl_oe_n) |-> $stable(fl_a))
        else $error("read address moved");
endmodule

bind fosr_host fosr_host_props u_props (
    .clock(clock), .rstn(rstn), .fl_a(fl_a), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
);
`default_nettype wire

//--- test/fosr_host_test.sv
// self-checking bench for the flash status polling controller
`default_nettype none
module fosr_host_test
    import fosr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clock;
    logic            rstn;
    logic [SA_W-1:0] sw_addr;
    logic [SD_W-1:0] sw_wdata;
    logic            sw_wr;
    logic            sw_rd;
    logic [SD_W-1:0] sw_rdata;
    logic [FA_W-1:0] fl_a;
    logic [FD_W-1:0] fl_dq_o;
    logic [FD_W-1:0] mdq;
    logic            fl_dq_oe;
    logic            fl_ce_n;
    logic            fl_oe_n;
    logic            fl_we_n;
    logic            rb_low;
    wire  [FD_W-1:0] fl_dq_i = fl_dq_oe ? fl_dq_o : mdq;
    // pull-up on the shared ready line; any device may pull it low
    wire             ready_busy_n_pin = !rb_low;
    int              n_mismatch = 0;
    int              n_tests = 0;
    logic [SD_W-1:0] st;

    fosr_host dut (
        .clock(clock), .rstn(rstn), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .fl_a(fl_a), .fl_dq_i(fl_dq_i),
        .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .ready_busy_n_pin(ready_busy_n_pin)
    );
    fosr_flash_model fm (
        .fl_a(fl_a), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .dq(mdq), .rb_low(rb_low)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [SA_W-1:0] a, input logic [SD_W-1:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clock);
        sw_wr <= 1'b0;
        // one edge passes so a following write never re-drives the strobe
        @(posedge clock);
    endtask
    task automatic rd(input logic [SA_W-1:0] a, output logic [SD_W-1:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clock);
        sw_rd <= 1'b0;
        @(negedge clock);
        d = sw_rdata;
        @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [SD_W-1:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded poll of the busy flag
    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            rd(REG_STAT, st);
            if (st[ST_BUSY] === 1'b0) break;
        end
        chk("busy", 32'h0, {31'h0, st[ST_BUSY]});
    endtask
    task automatic run(input logic [1:0] cmd);
        fm.n_rd = 0;
        fm.n_wr = 0;
        wr(REG_CTRL, {30'h0, cmd});
        repeat (2) @(posedge clock);
        wait_idle();
    endtask
    task automatic erase(input logic w0, w1, input int r, w, rej, uns);
        fm.win = w0;
        fm.win_after = w1;
        run(CMD_ERASE_ADD);
        chk("erase reads", r, fm.n_rd);
        chk("erase writes", w, fm.n_wr);
        chk("refused", rej, st[ST_REJECT]);
        chk("unsure", uns, st[ST_UNSURE]);
        if (w == 1) chk("erase word", 32'h30, {24'h0, fm.wd});
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        final_report();
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        sw_addr = '0;
        sw_wdata = '0;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(REG_STAT, st);
        chk("stat after reset", 32'h40, st);
        rd(8'h20, st);
        chk("unmapped read", 32'h0, st);
        run(CMD_POLL);
        chk("idle reads", 32'h2, fm.n_rd);
        chk("idle done", 32'h1, st[ST_DONE]);
        rd(REG_LAST, st);
        chk("array byte", 32'hA5, st);
        fm.busy_left = 2;
        run(CMD_POLL);
        chk("busy reads", 32'h4, fm.n_rd);
        chk("busy done", 32'h1, st[ST_FAIL:ST_DONE]);
        // stuck with the pulse limit exceeded: reset word must follow
        fm.busy_left = -1;
        fm.tmo = 1'b1;
        rd(REG_STAT, st);
        chk("ready low", 32'h0, st[ST_READY]);
        run(CMD_POLL);
        chk("fail reads", 32'h4, fm.n_rd);
        chk("fail writes", 32'h1, fm.n_wr);
        chk("reset word", 32'hF0, {24'h0, fm.wd});
        chk("reset addr", 32'h0, {10'h0, fm.wa});
        chk("fail flags", 32'h3, st[ST_TIMEOUT:ST_FAIL]);
        chk("ready back", 32'h1, st[ST_READY]);
        fm.busy_left = -1;
        wr(REG_CTRL, {30'h0, CMD_POLL});
        repeat (40) @(posedge clock);
        wr(REG_CTRL, 32'h1 << CTRL_ABORT);
        wait_idle();
        chk("aborted", 32'h1, st[ST_ABORTED]);
        chk("abort done", 32'h0, st[ST_DONE]);
        fm.busy_left = 0;
        run(CMD_POLL);
        chk("restart reads", 32'h2, fm.n_rd);
        chk("restart flags", 32'h1, {st[ST_ABORTED], st[ST_DONE]});
        // suspended erase: toggle frozen, line released, poll ends
        fm.busy_left = -1;
        fm.susp = 1'b1;
        run(CMD_POLL);
        chk("suspend reads", 32'h2, fm.n_rd);
        chk("suspend done", 32'h1, st[ST_DONE]);
        chk("suspend ready", 32'h1, st[ST_READY]);
        fm.susp = 1'b0;
        fm.busy_left = -1;
        wr(REG_ADDR, 32'h001F0000);
        wr(REG_DATA, 32'h30);
        run(CMD_WRITE);
        chk("word writes", 32'h1, fm.n_wr);
        chk("word reads", 32'h0, fm.n_rd);
        chk("word done", 32'h1, st[ST_DONE]);
        rd(REG_CTRL, st);
        chk("last command", 32'h2, st);
        rd(REG_ADDR, st);
        chk("addr reg", 32'h001F0000, st);
        rd(REG_DATA, st);
        chk("data reg", 32'h30, st);
        erase(1'b0, 1'b0, 2, 1, 0, 0);
        erase(1'b1, 1'b1, 1, 0, 1, 0);
        erase(1'b0, 1'b1, 2, 1, 0, 1);
        chk("erase addr", 32'h001F0000, {10'h0, fm.wa});
        fm.busy_left = 0;
        final_report();
    end
endmodule
`default_nettype wire
